// File: ccp_config_pins.sv
// Configuration control pins: chip select, update source, page select,
// init-done, user start-up clock, device-wide output enable and clear.
// Assumes one 20 MHz clk; the config engine supplies phase strobes.
//
// Overview of operation
// - Selected only when select_n low, select high
// - Non-parallel-async schemes: selects undriven general I/O
// - After parallel-async, selects follow dual-purpose setting
// - Update source high remote, low local
// - Three-bit page select picks one of eight
// - Without upgrade mode, those pins are general I/O
// - Option enabled: init timed from user clock
// - Init-done undriven while request low, early config
// - Init-done low once option bit loaded
// - Init-done released at init end, user mode
// - Global output enable low tristates all I/O
// - Global clear low clears all registers
// - Disabled optional pin acts as general I/O
// - Disabled init-done pin undriven, weak pull-up
`timescale 1ns/10ps
module ccp_config_pins
   import ccp_pkg::*;
#(
   parameter int PAGE_W      = CCP_PAGE_W,
   parameter int INIT_CYCLES = CCP_INIT_CYCLES
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Scheme and option settings
   input  wire logic [1:0]        config_scheme,
   input  wire logic              remote_upgrade_mode,
   input  wire logic              dual_purpose_keep,
   input  wire logic              opt_user_clock_en,
   input  wire logic              opt_init_done_en,
   input  wire logic              opt_global_oe_en,
   input  wire logic              opt_global_clear_en,
   // Configuration engine strobes
   input  wire logic              config_request_n,
   input  wire logic              option_bits_loaded,
   input  wire logic              config_data_done,
   input  wire logic              page_load,
   input  wire logic [PAGE_W-1:0] page_value,
   // Pins
   input  wire logic              config_select_n,
   input  wire logic              config_select,
   input  wire logic              update_source_select,
   input  wire logic              user_startup_clock,
   input  wire logic              global_output_enable,
   input  wire logic              global_clear_n,
   // Outputs
   output logic                   device_selected,
   output logic                   select_pins_oe,
   output logic                   update_remote,
   output logic                   update_pin_as_io,
   output logic [PAGE_W-1:0]      image_page_select,
   output logic [PAGE_W-1:0]      image_page_select_oe,
   output logic                   init_done_o,
   output logic                   init_done_oe,
   output logic                   init_done_pullup_en,
   output logic                   user_mode,
   output logic                   all_io_tristate,
   output logic                   all_regs_clear
);
   ccp_sync_if sync ();

   ccp_pin_sync u_sync (
      .clk                  (clk),
      .reset_n              (reset_n),
      .global_clear_n       (global_clear_n),
      .global_output_enable (global_output_enable),
      .update_source_select (update_source_select),
      .config_select_n      (config_select_n),
      .config_select        (config_select),
      .user_startup_clock   (user_startup_clock),
      .sync                 (sync)
   );

   ccp_state_e state_q;
   ccp_state_e state_d;
   logic [4:0] init_cnt_q;
   logic       uclk_prev_q;
   logic       option_done_q;

   // Decode
   wire is_ppa       = (config_scheme == CCP_SCH_PARALLEL_ASYNC);
   wire selected     = is_ppa && !sync.select_n && sync.select_hi;
   wire in_config    = (state_q == CCP_ST_CONFIG) || (state_q == CCP_ST_INIT);
   wire upgrade_on   = remote_upgrade_mode;
   // Internal source ticks every cycle; user clock counts its rising edges
   wire uclk_rise    = sync.user_clk && !uclk_prev_q;
   wire init_tick    = opt_user_clock_en ? uclk_rise : 1'b1;
   wire init_last    = (init_cnt_q == 5'(INIT_CYCLES - 1));
   wire init_drive   = opt_init_done_en && in_config && option_done_q;
   // Release on the edge that leaves config, not one cycle later
   wire next_cfg     = (state_d == CCP_ST_CONFIG) || (state_d == CCP_ST_INIT);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CCP_ST_IDLE:   if (config_request_n) state_d = CCP_ST_CONFIG;
         CCP_ST_CONFIG: if (config_data_done) state_d = CCP_ST_INIT;
         CCP_ST_INIT:   if (init_tick && init_last) state_d = CCP_ST_USER;
         CCP_ST_USER:   state_d = CCP_ST_USER;
         default:       state_d = CCP_ST_IDLE;
      endcase
      if (!config_request_n)
         state_d = CCP_ST_IDLE;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q     <= CCP_ST_IDLE;
         init_cnt_q  <= CCP_INIT_CNT_RST;
         uclk_prev_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         uclk_prev_q <= sync.user_clk;
         if (state_q != CCP_ST_INIT)
            init_cnt_q <= CCP_INIT_CNT_RST;
         else if (init_tick)
            init_cnt_q <= init_cnt_q + CCP_INIT_CNT_ONE;
      end
   end

   // Option bit arrives in the first data frame; lost on a new request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         option_done_q <= 1'b0;
      else if (!config_request_n)
         option_done_q <= 1'b0;
      else if (option_bits_loaded && state_q == CCP_ST_CONFIG)
         option_done_q <= 1'b1;
   end

   ccp_page_sel #(.PAGE_W(PAGE_W)) u_page (
      .clk        (clk),
      .reset_n    (reset_n),
      .upgrade_en (upgrade_on),
      .load       (page_load && upgrade_on),
      .page_in    (page_value),
      .page_o     (image_page_select),
      .page_oe    (image_page_select_oe)
   );

   // Registered outputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         device_selected     <= 1'b0;
         select_pins_oe      <= 1'b0;
         update_remote       <= 1'b0;
         update_pin_as_io    <= 1'b1;
         init_done_o         <= 1'b0;
         init_done_oe        <= 1'b0;
         init_done_pullup_en <= 1'b1;
         user_mode           <= 1'b0;
         all_io_tristate     <= 1'b0;
         all_regs_clear      <= 1'b0;
      end else begin
         device_selected     <= selected && in_config;
         // Never driven during config; in parallel-async user mode follows dual-purpose setting
         select_pins_oe      <= (state_q == CCP_ST_USER) && is_ppa && dual_purpose_keep;
         update_remote       <= upgrade_on && sync.update_remote;
         update_pin_as_io    <= !upgrade_on;
         init_done_o         <= 1'b0;
         init_done_oe        <= init_drive && next_cfg;
         init_done_pullup_en <= !opt_init_done_en;
         user_mode           <= (state_d == CCP_ST_USER);
         all_io_tristate     <= opt_global_oe_en && !sync.oe;
         all_regs_clear      <= opt_global_clear_en && !sync.clear_n;
      end
   end

   // Assertions
   chk_sel_qualify: assert property (@(posedge clk) disable iff (!reset_n)
      device_selected |-> $past(is_ppa && !sync.select_n && sync.select_hi))
      else $error("selected without both chip selects active");
   chk_sel_undriven: assert property (@(posedge clk) disable iff (!reset_n)
      $past(in_config) |-> !select_pins_oe)
      else $error("chip select pins driven during configuration");
   chk_sel_scheme: assert property (@(posedge clk) disable iff (!reset_n)
      !is_ppa |=> !select_pins_oe && !device_selected)
      else $error("chip select pins used outside parallel async scheme");
   chk_sel_user: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == CCP_ST_USER && is_ppa) |=> select_pins_oe == $past(dual_purpose_keep))
      else $error("chip select pins ignore dual-purpose setting");
   chk_upd_source: assert property (@(posedge clk) disable iff (!reset_n)
      ##1 update_remote == $past(upgrade_on && sync.update_remote))
      else $error("update source not followed");
   chk_page_load: assert property (@(posedge clk) disable iff (!reset_n)
      (page_load && upgrade_on) |=> image_page_select == $past(page_value))
      else $error("page select not loaded");
   chk_page_drive: assert property (@(posedge clk) disable iff (!reset_n)
      upgrade_on |=> image_page_select_oe == '1)
      else $error("page pins not driven in upgrade mode");
   chk_page_oe: assert property (@(posedge clk) disable iff (!reset_n)
      !upgrade_on |=> image_page_select_oe == '0)
      else $error("page pins driven outside upgrade mode");
   chk_page_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !upgrade_on |=> $stable(image_page_select))
      else $error("page select moved outside upgrade mode");
   chk_init_wait: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == CCP_ST_INIT && opt_user_clock_en && !uclk_rise && config_request_n)
         |=> state_q == CCP_ST_INIT && $stable(init_cnt_q))
      else $error("initialization advanced without user clock edge");
   chk_done_release: assert property (@(posedge clk) disable iff (!reset_n)
      !config_request_n |=> !init_done_oe)
      else $error("init done driven while request low");
   chk_done_low: assert property (@(posedge clk) disable iff (!reset_n)
      (init_drive && next_cfg) |=> init_done_oe && !init_done_o)
      else $error("init done not driven low after option load");
   chk_user_entry: assert property (@(posedge clk) disable iff (!reset_n)
      (state_q == CCP_ST_INIT && init_tick && init_last && config_request_n) |=> user_mode && !init_done_oe)
      else $error("user mode not entered at end of initialization");
   chk_user_release: assert property (@(posedge clk) disable iff (!reset_n)
      user_mode |-> !init_done_oe)
      else $error("init done held low in user mode");
   chk_oe_override: assert property (@(posedge clk) disable iff (!reset_n)
      (opt_global_oe_en && !sync.oe) |=> all_io_tristate)
      else $error("output enable override missed");
   chk_oe_follow: assert property (@(posedge clk) disable iff (!reset_n)
      (!opt_global_oe_en || sync.oe) |=> !all_io_tristate)
      else $error("outputs tristated without active override");
   chk_clr_override: assert property (@(posedge clk) disable iff (!reset_n)
      (opt_global_clear_en && !sync.clear_n) |=> all_regs_clear)
      else $error("global clear missed");
   chk_clr_follow: assert property (@(posedge clk) disable iff (!reset_n)
      (!opt_global_clear_en || sync.clear_n) |=> !all_regs_clear)
      else $error("registers cleared without active override");
   chk_pullup_off: assert property (@(posedge clk) disable iff (!reset_n)
      !opt_init_done_en |=> init_done_pullup_en && !init_done_oe)
      else $error("disabled pin not released with pull-up");

   cov_user_entry: cover property (@(posedge clk) disable iff (!reset_n) $rose(user_mode));
   cov_done_rise:  cover property (@(posedge clk) disable iff (!reset_n) $fell(init_done_oe) && user_mode);
   cov_user_clk:   cover property (@(posedge clk) disable iff (!reset_n) opt_user_clock_en && $rose(user_mode));
   cov_remote:     cover property (@(posedge clk) disable iff (!reset_n) update_remote);
   cov_done_drive: cover property (@(posedge clk) disable iff (!reset_n) $rose(init_done_oe));

endmodule : ccp_config_pins

// File: ccp_host_model.sv
// Host model: request line, engine strobes, chip selects, user clock.
// Assumes the bench calls its tasks; every change lands on falling clk.
`timescale 1ns/10ps
module ccp_host_model (
   // Clock
   input  wire logic clk,
   // Host drive
   output logic      config_request_n,
   output logic      option_bits_loaded,
   output logic      config_data_done,
   output logic      config_select_n,
   output logic      config_select,
   output logic      user_startup_clock
);
   initial begin
      config_request_n   = 1'b0;
      option_bits_loaded = 1'b0;
      config_data_done   = 1'b0;
      config_select_n    = 1'b0;
      config_select      = 1'b1;
      user_startup_clock = 1'b0;
   end
   // Gap sets a prompt or a slow host
   task automatic start_config(input int gap);
      @(negedge clk) config_request_n = 1'b1;
      repeat (gap) @(negedge clk);
      option_bits_loaded = 1'b1;
      @(negedge clk) option_bits_loaded = 1'b0;
   endtask : start_config
   task automatic finish_data;
      @(negedge clk) config_data_done = 1'b1;
      @(negedge clk) config_data_done = 1'b0;
   endtask : finish_data
   task automatic drop_request;
      @(negedge clk) config_request_n = 1'b0;
   endtask : drop_request
   task automatic set_selects(input logic sel_n, input logic sel);
      @(negedge clk) config_select_n = sel_n;
      config_select = sel;
   endtask : set_selects
   // User clock stands low outside the bursts
   task automatic user_clock_pulses(input int n);
      repeat (n) begin
         repeat (3) @(negedge clk);
         user_startup_clock = 1'b1;
         repeat (3) @(negedge clk);
         user_startup_clock = 1'b0;
      end
   endtask : user_clock_pulses
endmodule : ccp_host_model

// File: ccp_page_sel.sv
// Holds the image page select and its output enable.
// Assumes load strobe from the controller on clk.
`timescale 1ns/10ps
module ccp_page_sel
   import ccp_pkg::*;
#(
   parameter int PAGE_W = CCP_PAGE_W
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Control
   input  wire logic              upgrade_en,
   input  wire logic              load,
   input  wire logic [PAGE_W-1:0] page_in,
   // Pin drive
   output logic      [PAGE_W-1:0] page_o,
   output logic      [PAGE_W-1:0] page_oe
);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         page_o  <= PAGE_W'(CCP_PAGE_RST);
         page_oe <= '0;
      end else begin
         if (load)
            page_o <= page_in;
         page_oe <= {PAGE_W{upgrade_en}};
      end
   end
endmodule : ccp_page_sel

// File: ccp_pin_sync.sv
// Two-flop synchronisers for all asynchronous control pins.
// Assumes pins are unrelated to clk.
`timescale 1ns/10ps
module ccp_pin_sync
   import ccp_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Raw pins
   input  wire logic global_clear_n,
   input  wire logic global_output_enable,
   input  wire logic update_source_select,
   input  wire logic config_select_n,
   input  wire logic config_select,
   input  wire logic user_startup_clock,
   // Synchronised levels
   ccp_sync_if.src   sync
);
   localparam int N = 6;
   logic [N-1:0] meta_q;
   logic [N-1:0] stab_q;
   wire  [N-1:0] raw = {global_clear_n, global_output_enable, update_source_select,
                        config_select_n, config_select, user_startup_clock};

   // Idle levels chosen inactive, so no spurious clear or clock edge after reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= CCP_SYNC_RST;
         stab_q <= CCP_SYNC_RST;
      end else begin
         meta_q <= raw;
         stab_q <= meta_q;
      end
   end

   assign sync.clear_n       = stab_q[5];
   assign sync.oe            = stab_q[4];
   assign sync.update_remote = stab_q[3];
   assign sync.select_n      = stab_q[2];
   assign sync.select_hi     = stab_q[1];
   assign sync.user_clk      = stab_q[0];

endmodule : ccp_pin_sync

// File: ccp_pkg.sv
// Shared constants and types for the configuration control pin block.
// Assumes a single 20 MHz clock domain with active-low asynchronous reset.
package ccp_pkg;

   localparam int          CCP_CLK_HZ       = 20000000;
   localparam int          CCP_PAGE_W       = 3;
   localparam int          CCP_PAGE_COUNT   = 8;
   localparam int          CCP_SYNC_STAGES  = 2;
   localparam int          CCP_INIT_CYCLES  = 16;
   localparam logic [2:0]  CCP_PAGE_RST     = 3'h0;
   localparam logic [4:0]  CCP_INIT_CNT_RST = 5'h00;
   localparam logic [4:0]  CCP_INIT_CNT_ONE = 5'h01;
   // Synchroniser idle pattern: clear_n, oe high; update, select_hi, user clock low; select_n high
   localparam logic [5:0]  CCP_SYNC_RST     = 6'h34;

   typedef enum logic [1:0] {
      CCP_SCH_PASSIVE_SERIAL = 2'b00,
      CCP_SCH_FAST_PARALLEL  = 2'b01,
      CCP_SCH_PARALLEL_ASYNC = 2'b10
   } ccp_scheme_e;

   typedef enum logic [2:0] {
      CCP_ST_IDLE   = 3'b000,
      CCP_ST_CONFIG = 3'b001,
      CCP_ST_INIT   = 3'b010,
      CCP_ST_USER   = 3'b011
   } ccp_state_e;

endpackage : ccp_pkg

// File: ccp_sync_if.sv
// Carries synchronised pin levels from the input stage to the controller.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface ccp_sync_if;
   logic clear_n;
   logic oe;
   logic update_remote;
   logic select_n;
   logic select_hi;
   logic user_clk;
   modport src (output clear_n, oe, update_remote, select_n, select_hi, user_clk);
   modport dst (input  clear_n, oe, update_remote, select_n, select_hi, user_clk);
endinterface : ccp_sync_if

// File: test_config_control_pins.sv
// Self-checking bench for the configuration control pins.
// Assumes ccp_pkg and the host model; notes drained by a monitor.
`timescale 1ns/10ps
module test_config_control_pins;
   import ccp_pkg::*;
   localparam int INIT_N = 2;
   typedef struct {string nm; logic [15:0] mask; logic [15:0] exp;} ccp_note_s;
   logic clk, reset_n, remote_upgrade_mode, dual_purpose_keep;
   logic opt_user_clock_en, opt_init_done_en, opt_global_oe_en;
   logic opt_global_clear_en, page_load, update_source_select;
   logic global_output_enable, global_clear_n;
   logic [1:0] config_scheme;
   logic [2:0] page_value, image_page_select, image_page_select_oe;
   logic device_selected, select_pins_oe, update_remote, update_pin_as_io;
   logic init_done_o, init_done_oe, init_done_pullup_en, user_mode;
   logic all_io_tristate, all_regs_clear;
   wire  config_request_n, option_bits_loaded, config_data_done;
   wire  config_select_n, config_select, user_startup_clock;
   wire  [15:0] obs;
   // Open-drain line as seen with its external pull-up
   wire  init_line = init_done_oe ? init_done_o : 1'b1;
   logic [31:0] seed;
   int num_errors, num_checks;
   ccp_note_s notes[$];
   ccp_note_s n;
   assign obs = {device_selected, select_pins_oe, update_remote, update_pin_as_io,
                 image_page_select, image_page_select_oe, init_done_o, init_done_oe,
                 init_done_pullup_en, user_mode, all_io_tristate, all_regs_clear};
   ccp_host_model host (.clk(clk), .config_request_n(config_request_n),
      .option_bits_loaded(option_bits_loaded), .config_data_done(config_data_done),
      .config_select_n(config_select_n), .config_select(config_select),
      .user_startup_clock(user_startup_clock));
   ccp_config_pins #(.PAGE_W(3), .INIT_CYCLES(INIT_N)) dut (.clk(clk), .reset_n(reset_n),
      .config_scheme(config_scheme), .remote_upgrade_mode(remote_upgrade_mode),
      .dual_purpose_keep(dual_purpose_keep), .opt_user_clock_en(opt_user_clock_en),
      .opt_init_done_en(opt_init_done_en), .opt_global_oe_en(opt_global_oe_en),
      .opt_global_clear_en(opt_global_clear_en), .config_request_n(config_request_n),
      .option_bits_loaded(option_bits_loaded), .config_data_done(config_data_done),
      .page_load(page_load), .page_value(page_value), .config_select_n(config_select_n),
      .config_select(config_select), .update_source_select(update_source_select),
      .user_startup_clock(user_startup_clock), .global_output_enable(global_output_enable),
      .global_clear_n(global_clear_n), .device_selected(device_selected),
      .select_pins_oe(select_pins_oe), .update_remote(update_remote),
      .update_pin_as_io(update_pin_as_io), .image_page_select(image_page_select),
      .image_page_select_oe(image_page_select_oe), .init_done_o(init_done_o),
      .init_done_oe(init_done_oe), .init_done_pullup_en(init_done_pullup_en),
      .user_mode(user_mode), .all_io_tristate(all_io_tristate),
      .all_regs_clear(all_regs_clear));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic note(input string nm, input logic [15:0] mask, input logic [15:0] exp);
      notes.push_back(ccp_note_s'{nm, mask, exp});
   endtask : note
   // Sync plus output register needs three edges; four leaves margin
   task automatic settle;
      repeat (4) @(negedge clk);
   endtask : settle
   task automatic stop_test;
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   // Monitor side: user mode shows as a low-to-high step on the line
   task automatic wait_user;
      int k;
      logic was_low;
      was_low = 1'b0;
      for (k = 0; k < 60 && !(was_low && init_line === 1'b1); k++) begin
         was_low = (init_line === 1'b0);
         @(negedge clk);
      end
      if (!(was_low && init_line === 1'b1)) begin
         num_errors++;
         stop_test();
      end
   endtask : wait_user
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Outputs only move on rising clk, so 5 ns after the falling edge is settled
   initial forever begin
      @(negedge clk);
      #5;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         check(n.nm, obs & n.mask, n.exp);
      end
   end
   initial begin
      {reset_n, remote_upgrade_mode, dual_purpose_keep, opt_user_clock_en} = 4'h0;
      {opt_init_done_en, opt_global_oe_en, opt_global_clear_en, page_load} = 4'h0;
      {update_source_select, global_output_enable, global_clear_n} = 3'h0;
      config_scheme = CCP_SCH_PASSIVE_SERIAL;
      page_value = 3'h0;
      seed = 32'h21c353a5;
      num_errors = 0;
      num_checks = 0;
      repeat (12) @(negedge clk);
      note("reset", 16'hffff, 16'h1008);
      @(negedge clk) reset_n = 1'b1;
      settle();
      note("idle_ps", 16'hd1d8, 16'h1008);
      host.start_config(1);
      settle();
      note("cfg_ps", 16'hc01b, 16'h0008);
      {opt_global_oe_en, opt_global_clear_en} = 2'b11;
      for (int i = 0; i < 4; i++) begin
         {global_clear_n, global_output_enable} = 2'(i);
         settle();
         note("override", 16'h0003, {14'h0, ~i[0], ~i[1]});
      end
      remote_upgrade_mode = 1'b1;
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         update_source_select = seed[0];
         page_value = seed[3:1];
         page_load = 1'b1;
         @(negedge clk) page_load = 1'b0;
         settle();
         note("upgrade", 16'h3fc0, {2'b00, seed[0], 1'b0, seed[3:1], 9'h1c0});
      end
      remote_upgrade_mode = 1'b0;
      page_value = ~page_value;
      page_load = 1'b1;
      @(negedge clk) page_load = 1'b0;
      settle();
      note("no_upgrade", 16'h3fc0, {3'b000, 1'b1, seed[3:1], 9'h000});
      host.drop_request();
      config_scheme = CCP_SCH_PARALLEL_ASYNC;
      {opt_init_done_en, dual_purpose_keep} = 2'b11;
      settle();
      note("pre_cfg", 16'h801c, 16'h0000);
      host.start_config(5);
      settle();
      note("cfg_ppa", 16'hc034, 16'h8010);
      for (int j = 0; j < 3; j++) begin
         host.set_selects(j != 1, j == 0);
         settle();
         note("deselect", 16'h8000, 16'h0000);
      end
      host.set_selects(1'b0, 1'b1);
      settle();
      note("reselect", 16'h8000, 16'h8000);
      host.finish_data();
      wait_user();
      note("init_rise", 16'h0004, 16'h0004);
      settle();
      note("user", 16'hc014, 16'h4004);
      host.drop_request();
      opt_user_clock_en = 1'b1;
      settle();
      note("dropped", 16'h0014, 16'h0000);
      host.start_config(1);
      host.finish_data();
      repeat (30) @(negedge clk);
      note("usr_clk_idle", 16'h0014, 16'h0010);
      host.user_clock_pulses(INIT_N - 1);
      settle();
      note("usr_clk_short", 16'h0014, 16'h0010);
      host.user_clock_pulses(1);
      settle();
      note("usr_clk_run", 16'h0014, 16'h0004);
      repeat (2) @(negedge clk);
      stop_test();
   end
endmodule : test_config_control_pins
